// File: core/opc_panel.sv
// Front panel mode controller: buttons, display mode, function index, front port, failed-reclose latch.
// Assumes button pins are raw asynchronous levels; relay state inputs come from logic on clk.
// Limitation: value editing, target lists and settings storage live outside this block.
//
// How it works
// RULE1 - A 2 x 16 character display is driven with four navigation buttons: select, lower, raise, enter.
// RULE2 - The display is organised as a function field, a value field and a mode field.
// RULE3 - Seven display modes exist and the current mode name is shown at the top right.
// RULE4 - After two minutes without a button press the display returns to the default mode for the relay state.
// RULE5 - Holding select steps through the modes in fixed order about once per second.
// RULE6 - Lower and raise step the function index back and forth, repeating about once per second when held.
// RULE7 - Reset clears the failed-reclose indicator and contact and returns to ready or lockout mode.
// RULE8 - The front port enable button activates the front port and the rear port is then disabled.
// RULE9 - In ready mode a reclosing sequence starts as soon as the reclosure 1 initiation is seen.
// RULE10 - At cycle end the display goes to ready on success or lockout when no more reclosure is possible.
// RULE11 - In the function-scroll state one select press advances to the next mode.
// RULE12 - All buttons are debounced, act on a registered press edge, and every press restarts the idle timer.
`timescale 1ns/1ps
module opc_panel #(
  parameter longint IDLE_CYCLES = opc_pkg::IDLE_CYCLES,
  parameter int REPEAT_CYCLES = opc_pkg::REPEAT_CYCLES,
  parameter int DEBOUNCE_CYCLES = opc_pkg::DEBOUNCE_CYCLES,
  parameter int NUM_FUNCS = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic btn_select,
  input wire logic btn_lower,
  input wire logic btn_raise,
  input wire logic btn_enter,
  input wire logic btn_reset,
  input wire logic btn_front_port,
  input wire logic front_port_done,
  input wire logic [1:0] relay_state,
  input wire logic recl1_initiate,
  input wire logic cycle_end_ok,
  input wire logic cycle_end_lockout,
  input wire logic failed_reclose_evt,
  output logic [6:0] disp_mode,
  output logic [opc_pkg::FUNC_W-1:0] disp_func,
  output logic enter_press,
  output logic cycle_start,
  output logic cycle_active,
  output logic failed_reclose_led,
  output logic failed_reclose_contact,
  output logic front_port_en,
  output logic rear_port_en
);
  // Button pins, debounced levels and one-cycle press strobes
  logic [opc_pkg::NUM_BUTTONS-1:0] pins, lvl, prs;
  // Current display mode and its next value
  opc_pkg::opc_mode_type mode_r, mode_nxt;
  // Function index inside the current mode
  logic [opc_pkg::FUNC_W-1:0] func_r, func_nxt;
  // Two minutes at the system clock does not fit in 32 bits
  logic [63:0] idle_r, idle_nxt;
  // Hold-repeat timer
  logic [31:0] rep_r, rep_nxt;
  // Failed-reclose latch, front port session, reclosing cycle
  logic fail_r, fail_nxt;
  logic front_r, front_nxt;
  logic cyc_r, cyc_nxt;
  // Pulse outputs are registered so they come from flip-flops
  logic start_r, start_nxt;
  logic enter_r, enter_nxt;
  logic step_sel, step_lo, step_hi, rep_tick, any_press;

  // Next mode in the fixed scroll order
  // Disabled wraps back to ready, closing the loop
  function automatic opc_pkg::opc_mode_type next_mode(input opc_pkg::opc_mode_type m);
    case (m)
      opc_pkg::MODE_READY: next_mode = opc_pkg::MODE_SETTINGS;
      opc_pkg::MODE_SETTINGS: next_mode = opc_pkg::MODE_TARGETS;
      opc_pkg::MODE_TARGETS: next_mode = opc_pkg::MODE_STATISTIC;
      opc_pkg::MODE_STATISTIC: next_mode = opc_pkg::MODE_TEST;
      opc_pkg::MODE_TEST: next_mode = opc_pkg::MODE_LOCKOUT;
      opc_pkg::MODE_LOCKOUT: next_mode = opc_pkg::MODE_DISABLED;
      default: next_mode = opc_pkg::MODE_READY;
    endcase
  endfunction : next_mode

  // Default mode follows the relay state
  // A cycling relay keeps ready as its default until the cycle ends
  function automatic opc_pkg::opc_mode_type default_mode(input logic [1:0] st);
    if (st == opc_pkg::RELAY_LOCKOUT) begin
      default_mode = opc_pkg::MODE_LOCKOUT;
    end else if (st == opc_pkg::RELAY_DISABLED) begin
      default_mode = opc_pkg::MODE_DISABLED;
    end else begin
      default_mode = opc_pkg::MODE_READY;
    end
  endfunction : default_mode

  // Pin order matches the button indices of the package
  assign pins = {btn_front_port, btn_reset, btn_enter, btn_raise, btn_lower, btn_select};

  // One debouncer per button; press is a registered one-cycle edge
  // Separate filters so a bouncing key cannot mask another
  for (genvar i = 0; i < opc_pkg::NUM_BUTTONS; i++) begin : g_db
    opc_debounce #(.STABLE_CYCLES(DEBOUNCE_CYCLES)) u_db (
      .clk(clk),
      .nrst(nrst),
      .pin(pins[i]),
      .level(lvl[i]),
      .press(prs[i])
    ); // RULE12
  end

  // A fresh press of any button restarts the idle timer; holding does not
  assign any_press = |prs; // RULE12
  // Repeat tick fires while select, lower or raise stays held
  assign rep_tick = (rep_r == 32'(REPEAT_CYCLES - 1));
  // A held key steps again on every repeat tick
  assign step_sel = prs[opc_pkg::BTN_SELECT] | (lvl[opc_pkg::BTN_SELECT] & rep_tick); // RULE5 RULE11
  assign step_lo = prs[opc_pkg::BTN_LOWER] | (lvl[opc_pkg::BTN_LOWER] & rep_tick); // RULE6
  assign step_hi = prs[opc_pkg::BTN_RAISE] | (lvl[opc_pkg::BTN_RAISE] & rep_tick); // RULE6

  // Hold-repeat and idle timers
  always_comb begin
    // A fresh press restarts the count, so the first repeat comes a full period later
    rep_nxt = 32'h0;
    if ((|lvl[opc_pkg::BTN_RAISE:opc_pkg::BTN_SELECT]) && !any_press && !rep_tick) begin
      rep_nxt = rep_r + 32'h1;
    end
    // The idle timer wraps by itself, so the default is re-applied every period
    idle_nxt = idle_r + 64'h1;
    if (any_press || idle_r == 64'(IDLE_CYCLES - 1)) begin
      idle_nxt = 64'h0; // RULE12
    end
  end

  // Mode, function index, latches and ports
  always_comb begin
    mode_nxt = mode_r;
    func_nxt = func_r;
    fail_nxt = fail_r;
    front_nxt = front_r;
    cyc_nxt = cyc_r;
    start_nxt = 1'b0;
    // Enter is only reported; value editing lives beyond this block
    enter_nxt = prs[opc_pkg::BTN_ENTER]; // RULE1
    // Failed-reclose latch: a new event wins over reset
    if (failed_reclose_evt) begin
      fail_nxt = 1'b1;
    end else if (prs[opc_pkg::BTN_RESET]) begin
      fail_nxt = 1'b0; // RULE7
    end
    // Front port stays on until its session ends
    if (prs[opc_pkg::BTN_FRONT]) begin
      front_nxt = 1'b1; // RULE8
    end else if (front_port_done) begin
      front_nxt = 1'b0;
    end
    // Reclosing cycle tracking
    // Only ready mode with a ready relay may start; a stray initiate elsewhere is ignored
    if (!cyc_r && mode_r == opc_pkg::MODE_READY && relay_state == opc_pkg::RELAY_READY && recl1_initiate) begin
      cyc_nxt = 1'b1; // RULE9
      start_nxt = 1'b1;
    end else if (cyc_r && (cycle_end_ok || cycle_end_lockout)) begin
      cyc_nxt = 1'b0;
    end
    // Display mode selection, highest priority first
    if (cyc_r && cycle_end_lockout) begin
      mode_nxt = opc_pkg::MODE_LOCKOUT; // RULE10
      func_nxt = '0;
    end else if (cyc_r && cycle_end_ok) begin
      mode_nxt = opc_pkg::MODE_READY; // RULE10
      func_nxt = '0;
    end else if (prs[opc_pkg::BTN_RESET]) begin
      mode_nxt = (relay_state == opc_pkg::RELAY_LOCKOUT) ? opc_pkg::MODE_LOCKOUT : opc_pkg::MODE_READY; // RULE7
      func_nxt = '0;
    end else if (step_sel) begin
      mode_nxt = next_mode(mode_r); // RULE5 RULE11 RULE3
      func_nxt = '0;
    end else if (step_hi) begin
      // Lower and raise wrap around the function list
      func_nxt = (func_r == opc_pkg::FUNC_W'(NUM_FUNCS - 1)) ? '0 : func_r + 1'b1; // RULE6
    end else if (step_lo) begin
      func_nxt = (func_r == '0) ? opc_pkg::FUNC_W'(NUM_FUNCS - 1) : func_r - 1'b1; // RULE6
    end else if (idle_r == 64'(IDLE_CYCLES - 1)) begin
      // Lowest priority: any button step in the same cycle wins
      mode_nxt = default_mode(relay_state); // RULE4
      func_nxt = '0;
    end
  end

  // State registers; reset shows ready mode with every latch clear
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_r <= opc_pkg::MODE_READY;
      func_r <= '0;
      idle_r <= 64'h0;
      rep_r <= 32'h0;
      fail_r <= 1'b0;
      front_r <= 1'b0;
      cyc_r <= 1'b0;
      start_r <= 1'b0;
      enter_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      func_r <= func_nxt;
      idle_r <= idle_nxt;
      rep_r <= rep_nxt;
      fail_r <= fail_nxt;
      front_r <= front_nxt;
      cyc_r <= cyc_nxt;
      start_r <= start_nxt;
      enter_r <= enter_nxt;
    end
  end

  // Mode code drives the top-right field, func index the function/value fields
  assign disp_mode = mode_r; // RULE2 RULE3
  assign disp_func = func_r; // RULE2
  assign enter_press = enter_r;
  assign cycle_start = start_r;
  assign cycle_active = cyc_r;
  // Indicator and contact share one latch so they never disagree
  assign failed_reclose_led = fail_r;
  assign failed_reclose_contact = fail_r; // RULE7
  assign front_port_en = front_r;
  // Rear port is blocked for as long as the front session lasts
  assign rear_port_en = ~front_r; // RULE8
endmodule : opc_panel

// File: core/opc_pkg.sv
// Package for the operator panel mode controller: mode codes, timing counts, field layout.
// Assumes a single 100 MHz system clock.
package opc_pkg;
  localparam int CLK_HZ = 100000000;
  localparam int IDLE_TIMEOUT_S = 120;              // Two minutes of no button activity
  localparam int REPEAT_PERIOD_MS = 1000;           // Hold-repeat about once per second
  localparam int DEBOUNCE_MS = 10;
  localparam longint IDLE_CYCLES = longint'(IDLE_TIMEOUT_S) * longint'(CLK_HZ);
  localparam int REPEAT_CYCLES = (CLK_HZ / 1000) * REPEAT_PERIOD_MS;
  localparam int DEBOUNCE_CYCLES = (CLK_HZ / 1000) * DEBOUNCE_MS;
  localparam int DISP_LINES = 2;
  localparam int DISP_CHARS = 16;
  localparam int NUM_NAV_BUTTONS = 4;
  localparam int NUM_BUTTONS = 6;
  // Button indices in the debounced vector
  localparam int BTN_SELECT = 0;
  localparam int BTN_LOWER = 1;
  localparam int BTN_RAISE = 2;
  localparam int BTN_ENTER = 3;
  localparam int BTN_RESET = 4;
  localparam int BTN_FRONT = 5;
  localparam int FUNC_W = 6;
  // Display modes in fixed scroll order
  typedef enum logic [6:0] {
    MODE_READY = 7'h01,
    MODE_SETTINGS = 7'h02,
    MODE_TARGETS = 7'h04,
    MODE_STATISTIC = 7'h08,
    MODE_TEST = 7'h10,
    MODE_LOCKOUT = 7'h20,
    MODE_DISABLED = 7'h40
  } opc_mode_type;
  // Relay state reported by the reclosing logic
  localparam logic [1:0] RELAY_READY = 2'h0;
  localparam logic [1:0] RELAY_LOCKOUT = 2'h1;
  localparam logic [1:0] RELAY_DISABLED = 2'h2;
  localparam logic [1:0] RELAY_CYCLING = 2'h3;
endpackage : opc_pkg

// File: core/opc_debounce.sv
// Debouncer for one push-button pin: two-flop synchroniser, stable-count filter, press edge.
// Assumes the pin is asynchronous to clk and active high.
`timescale 1ns/1ps
module opc_debounce #(
  parameter int STABLE_CYCLES = opc_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  output logic level,
  output logic press
);
  logic sync1_r, sync2_r, level_r, level_nxt, press_r, press_nxt;
  logic [31:0] cnt_r, cnt_nxt;

  // Filter: accept new level only after it stays stable
  always_comb begin
    level_nxt = level_r;
    press_nxt = 1'b0;
    cnt_nxt = 32'h0;
    if (sync2_r != level_r) begin
      if (cnt_r >= 32'(STABLE_CYCLES - 1)) begin
        level_nxt = sync2_r;
        press_nxt = sync2_r;
      end else begin
        cnt_nxt = cnt_r + 32'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      level_r <= 1'b0;
      press_r <= 1'b0;
      cnt_r <= 32'h0;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
      level_r <= level_nxt;
      press_r <= press_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  assign level = level_r;
  assign press = press_r;
endmodule : opc_debounce

// File: test/opc_panel_chk.sv
// Port assertions for the panel mode controller.
// Assumes one clk domain with async active-low nrst.
`timescale 1ns/1ps
module opc_panel_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [1:0] relay_state,
  input wire logic recl1_initiate,
  input wire logic cycle_end_ok,
  input wire logic cycle_end_lockout,
  input wire logic failed_reclose_evt,
  input wire logic [6:0] disp_mode,
  input wire logic enter_press,
  input wire logic cycle_start,
  input wire logic cycle_active,
  input wire logic failed_reclose_led,
  input wire logic failed_reclose_contact,
  input wire logic front_port_en,
  input wire logic rear_port_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Output relations
  a_rear_port_off: assert property (rear_port_en == !front_port_en) else $error("rear port not off");
  a_start_pulse: assert property (cycle_start |-> cycle_active ##1 !cycle_start) else $error("start pulse bad");
  a_start_cause: assert property ($rose(cycle_active) |-> cycle_start && $past(recl1_initiate)
    && $past(disp_mode) == opc_pkg::MODE_READY && $past(relay_state) == opc_pkg::RELAY_READY) else $error("bad start");
  a_end_ready: assert property (cycle_active && cycle_end_ok && !cycle_end_lockout
    |=> !cycle_active && disp_mode == opc_pkg::MODE_READY) else $error("end ok not ready");
  a_end_lockout: assert property (cycle_active && cycle_end_lockout
    |=> !cycle_active && disp_mode == opc_pkg::MODE_LOCKOUT) else $error("end not lockout");
  a_fail_latch: assert property (failed_reclose_evt |=> failed_reclose_led && failed_reclose_contact) else $error("no latch");
  a_fail_pair: assert property (failed_reclose_led == failed_reclose_contact) else $error("led contact differ");
  a_mode_onehot: assert property ($onehot(disp_mode)) else $error("mode not one-hot");
  a_enter_once: assert property (enter_press |=> !enter_press) else $error("enter pulse long");
  // Main scenarios seen
  cover property (cycle_start);
  cover property ($fell(failed_reclose_led));
  cover property ($rose(front_port_en));
endmodule : opc_panel_chk
bind opc_panel opc_panel_chk u_chk (.clk(clk), .nrst(nrst), .relay_state(relay_state),
  .recl1_initiate(recl1_initiate), .cycle_end_ok(cycle_end_ok), .cycle_end_lockout(cycle_end_lockout),
  .failed_reclose_evt(failed_reclose_evt), .disp_mode(disp_mode), .enter_press(enter_press),
  .cycle_start(cycle_start), .cycle_active(cycle_active), .failed_reclose_led(failed_reclose_led),
  .failed_reclose_contact(failed_reclose_contact), .front_port_en(front_port_en), .rear_port_en(rear_port_en));

// File: test/opc_operator.sv
// Operator model: turns held-button requests into pin levels.
// Assumes requests change just after a rising clk edge.
`timescale 1ns/1ps
module opc_operator (
  input wire logic clk,
  input wire logic [5:0] hold,
  output logic [5:0] pins
);
  logic [5:0] b1 = 6'h00;
  logic [5:0] b2 = 6'h00;
  // Contacts bounce open once right after closing
  // Requests are sampled on the edge and pins move 1 ns later, so there is no race with the bench
  always @(posedge clk) begin
    b1 <= hold;
    b2 <= b1;
    pins <= #1 hold & ~(b1 & ~b2);
  end
  initial pins = 6'h00;
endmodule : opc_operator

// File: test/opc_panel_tb_top.sv
// Testbench for the panel controller with an operator model.
// Assumes short debounce, repeat and idle counts.
`timescale 1ns/1ps
module opc_panel_tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [5:0] hold = 6'h00;
  logic [5:0] pins;
  logic done = 1'b0;
  logic [1:0] rs = 2'h0;
  logic init = 1'b0;
  logic e_ok = 1'b0;
  logic e_lo = 1'b0;
  logic evt = 1'b0;
  logic [6:0] mode;
  logic [5:0] func;
  logic act, fp, rp, led, con;
  logic ent, cst;
  logic [6:0] em;
  logic [5:0] ef;
  int mismatches = 0;
  int checked = 0;
  int k;
  int b;
  int n_ent = 0;
  int n_st = 0;
  always #5 clk = ~clk;
  opc_operator u_op (.clk(clk), .hold(hold), .pins(pins));
  opc_panel #(.IDLE_CYCLES(2000), .REPEAT_CYCLES(50), .DEBOUNCE_CYCLES(4)) uut (.clk(clk), .nrst(nrst),
    .btn_select(pins[0]), .btn_lower(pins[1]), .btn_raise(pins[2]), .btn_enter(pins[3]), .btn_reset(pins[4]),
    .btn_front_port(pins[5]), .front_port_done(done), .relay_state(rs), .recl1_initiate(init),
    .cycle_end_ok(e_ok), .cycle_end_lockout(e_lo), .failed_reclose_evt(evt), .disp_mode(mode),
    .disp_func(func), .enter_press(ent), .cycle_start(cst), .cycle_active(act), .failed_reclose_led(led),
    .failed_reclose_contact(con), .front_port_en(fp), .rear_port_en(rp));
  // Count one-cycle strobes at each edge, where they are settled
  always @(posedge clk) begin
    if (ent === 1'b1) begin
      n_ent++;
    end
    if (cst === 1'b1) begin
      n_st++;
    end
  end
  // Fixed scroll order, wrapping after disabled
  function automatic logic [6:0] nm(input logic [6:0] m);
    return (m == 7'h40) ? 7'h01 : {m[5:0], 1'b0};
  endfunction : nm
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Hold for n cycles, then release for 14; n of 14 passes the debounce filter but stays under one repeat step
  task automatic press(input int i, input int n);
    hold[i] = 1'b1;
    cyc(n);
    hold[i] = 1'b0;
    cyc(14);
  endtask : press
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(2);
  endtask : pulse
  task automatic chk(input logic [6:0] seen, input logic [6:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic end_of_test;
    if (mismatches == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test
  initial begin
    void'($urandom(35));
    cyc(20);
    nrst = 1'b1;
    cyc(2);
    chk({5'h00, rp, fp}, 7'h02);
    // Random lower/raise, first one wraps below zero
    ef = 6'h00;
    for (k = 0; k < 10; k++) begin
      b = (k == 0) ? 1 : $urandom_range(1, 2);
      press(b, 14);
      ef = (b == 2) ? ((ef + 6'h01) & 6'h0F) : ((ef - 6'h01) & 6'h0F);
      chk({1'b0, func}, {1'b0, ef});
    end
    press(3, 14);
    chk(7'(n_ent), 7'h01);
    chk({1'b0, func}, {1'b0, ef});
    em = 7'h01;
    for (k = 0; k < 7; k++) begin
      press(0, 14);
      em = nm(em);
      chk(mode, em);
      chk({1'b0, func}, 7'h00);
    end
    press(0, 130);
    em = nm(nm(nm(em)));
    chk(mode, em);
    // Idle return to the default for a locked-out relay
    rs = opc_pkg::RELAY_LOCKOUT;
    cyc(1850);
    chk(mode, em);
    for (k = 0; k < 300 && mode !== 7'h20; k++) cyc(1);
    chk({1'b0, func}, 7'h00);
    chk(mode, 7'h20);
    if (k == 300) end_of_test();
    pulse(evt);
    chk({5'h00, led, con}, 7'h03);
    press(4, 14);
    chk({led, con, mode[4:0]}, 7'h00);
    rs = opc_pkg::RELAY_READY;
    press(4, 14);
    chk(mode, 7'h01);
    pulse(init);
    chk({6'h00, act}, 7'h01);
    chk(7'(n_st), 7'h01);
    rs = opc_pkg::RELAY_CYCLING;
    pulse(e_lo);
    chk({act, mode[5:0]}, 7'h20);
    rs = opc_pkg::RELAY_READY;
    press(4, 14);
    pulse(init);
    chk({6'h00, act}, 7'h01);
    pulse(e_ok);
    chk({act, mode[5:0]}, 7'h01);
    chk(7'(n_st), 7'h02);
    press(5, 14);
    chk({5'h00, rp, fp}, 7'h01);
    pulse(done);
    chk({5'h00, rp, fp}, 7'h02);
    end_of_test();
  end
endmodule : opc_panel_tb_top
